// File: hw/wdt_pkg.sv
// Shared constants for the watchdog control block.
// Assumes a 32-bit AXI4-Lite register port, one word per register.
package wdt_pkg;
	localparam int          ADDR_W    = 8;
	localparam logic [7:0]  OFF_CTRL  = 8'h00;
	localparam logic [7:0]  OFF_GCTL  = 8'h04;
	localparam logic [7:0]  OFF_PRDLO = 8'h08;
	localparam logic [7:0]  OFF_PRDHI = 8'h0C;
	localparam logic [7:0]  OFF_CNTLO = 8'h10;
	localparam logic [7:0]  OFF_CNTHI = 8'h14;
	localparam logic [7:0]  OFF_ISTS  = 8'h18;
	localparam logic [7:0]  OFF_IMASK = 8'h1C;
	localparam int          KEY_LSB   = 16;
	localparam int          FLAG_BIT  = 15;
	localparam int          EN_BIT    = 14;
	localparam int          IDLE_LSB  = 12;
	localparam int          MODE_LSB  = 2;
	localparam int          UPRUN_BIT = 1;
	localparam int          LORUN_BIT = 0;
	localparam logic [15:0] SVC_KEY1  = 16'hA5C6;
	localparam logic [15:0] SVC_KEY2  = 16'hDA7E;
	localparam logic [15:0] KEY_RST   = 16'h0000;
	localparam logic [1:0]  IDLE_KEY1 = 2'h1;
	localparam logic [1:0]  IDLE_KEY2 = 2'h2;
	localparam logic [1:0]  IDLE_STOP = 2'h0;
	localparam logic [1:0]  MODE_WD   = 2'h2;
	localparam logic [3:0]  GCTL_RST  = 4'h0;
	localparam logic [31:0] PRD_RST   = 32'h0000_0000;
	localparam logic [1:0]  RESP_OK   = 2'h0;
	localparam logic [1:0]  RESP_ERR  = 2'h2;
	localparam int          IRQ_W     = 3;
	localparam int          IRQ_TO    = 0;
	localparam int          IRQ_SVC   = 1;
	localparam int          IRQ_BAD   = 2;
	localparam logic [2:0]  IRQ_RST   = 3'h0;
	typedef enum logic [1:0] {WD_INIT, WD_PRE, WD_ACTIVE} wd_state_t;
endpackage

// File: hw/key_seq.sv
// Two-step key detector: FIRST then SECOND completes a sequence.
// Assumes wr is a one-cycle write strobe with val valid beside it.
`timescale 1ns/1ps
module key_seq #(
	parameter int           W      = 16,
	parameter logic [W-1:0] FIRST  = '0,
	parameter logic [W-1:0] SECOND = '1
) (
	input  wire logic         aclk,    // Clock
	input  wire logic         aresetn, // Sync reset, low
	input  wire logic         clr,     // Drop a half sequence
	input  wire logic         wr,      // Key write strobe
	input  wire logic [W-1:0] val,     // Written key
	output logic              armed,   // First key seen
	output logic              done,    // Sequence complete
	output logic              bad      // Wrong or out-of-order key
);
	logic armed_r;
	logic armed_nxt;
	wire  is_first  = wr && (val == FIRST);
	wire  is_second = wr && (val == SECOND) && armed_r;

	assign done = is_second;
	assign bad  = wr && !is_first && !is_second;
	assign armed = armed_r;
	assign armed_nxt = clr ? 1'b0 : (wr ? is_first : armed_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) armed_r <= 1'b0;
		else armed_r <= armed_nxt;
	end
endmodule

// File: hw/axil_port.sv
// AXI4-Lite slave front end: turns channel handshakes into strobes.
// Assumes the register file answers reads combinationally.
`timescale 1ns/1ps
module axil_port
	import wdt_pkg::*;
(
	input  wire logic              aclk,     // Clock
	input  wire logic              aresetn,  // Sync reset, low
	input  wire logic [ADDR_W-1:0] awaddr,   // Write address
	input  wire logic              awvalid,  // Write address valid
	output logic                   awready,  // Write address ready
	input  wire logic [31:0]       wdata,    // Write data
	input  wire logic [3:0]        wstrb,    // Byte enables
	input  wire logic              wvalid,   // Write data valid
	output logic                   wready,   // Write data ready
	output logic [1:0]             bresp,    // Write response
	output logic                   bvalid,   // Response valid
	input  wire logic              bready,   // Response ready
	input  wire logic [ADDR_W-1:0] araddr,   // Read address
	input  wire logic              arvalid,  // Read address valid
	output logic                   arready,  // Read address ready
	output logic [31:0]            rdata,    // Read data
	output logic [1:0]             rresp,    // Read response
	output logic                   rvalid,   // Read data valid
	input  wire logic              rready,   // Read data ready
	output logic                   wr_go,    // Register write strobe
	output logic [ADDR_W-1:0]      wr_addr,  // Write address held
	output logic [31:0]            wr_data,  // Write data held
	output logic [3:0]             wr_strb,  // Byte enables held
	input  wire logic              wr_hit,   // Write address mapped
	output logic                   rd_go,    // Register read strobe
	input  wire logic [31:0]       rd_data,  // Read value
	input  wire logic              rd_hit    // Read address mapped
);
	logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0]        bresp_r, rresp_r;
	logic [31:0]       rdata_r, wdata_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [3:0]        wstrb_r;
	wire               aw_take = awvalid && awready_r;
	wire               w_take  = wvalid && wready_r;

	// Both halves held and no response pending
	assign wr_go   = !awready_r && !wready_r && !bvalid_r;
	assign wr_addr = awaddr_r;
	assign wr_data = wdata_r;
	assign wr_strb = wstrb_r;
	assign rd_go   = arvalid && arready_r;
	assign {awready, wready, bvalid, bresp} =
		{awready_r, wready_r, bvalid_r, bresp_r};
	assign {arready, rvalid, rresp, rdata} =
		{arready_r, rvalid_r, rresp_r, rdata_r};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OK;
			awaddr_r  <= '0;
			wdata_r   <= '0;
			wstrb_r   <= '0;
		end else begin
			if (aw_take) begin
				awaddr_r  <= awaddr;
				awready_r <= 1'b0;
			end
			if (w_take) begin
				wdata_r  <= wdata;
				wstrb_r  <= wstrb;
				wready_r <= 1'b0;
			end
			if (wr_go) begin
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_hit ? RESP_OK : RESP_ERR;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end else if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rresp_r   <= RESP_OK;
			rdata_r   <= '0;
		end else if (rd_go) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rresp_r   <= rd_hit ? RESP_OK : RESP_ERR;
			rdata_r   <= rd_hit ? rd_data : 32'h0000_0000;
		end else if (rvalid_r && rready) begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b1;
		end
	end
endmodule

// File: hw/watchdog_control.sv
// Watchdog control, counter and status behind an AXI4-Lite port.
// Assumes aclk at 40 MHz and one master on the register bus.
`timescale 1ns/1ps
module watchdog_control
	import wdt_pkg::*;
#(
	parameter int CNT_W = 64
) (
	input  wire logic              aclk,         // Clock, 40 MHz
	input  wire logic              aresetn,      // Sync reset, low
	input  wire logic [ADDR_W-1:0] awaddr,       // Write address
	input  wire logic              awvalid,      // Write address valid
	output logic                   awready,      // Write address ready
	input  wire logic [31:0]       wdata,        // Write data
	input  wire logic [3:0]        wstrb,        // Byte enables
	input  wire logic              wvalid,       // Write data valid
	output logic                   wready,       // Write data ready
	output logic [1:0]             bresp,        // Write response
	output logic                   bvalid,       // Response valid
	input  wire logic              bready,       // Response ready
	input  wire logic [ADDR_W-1:0] araddr,       // Read address
	input  wire logic              arvalid,      // Read address valid
	output logic                   arready,      // Read address ready
	output logic [31:0]            rdata,        // Read data
	output logic [1:0]             rresp,        // Read response
	output logic                   rvalid,       // Read data valid
	input  wire logic              rready,       // Read data ready
	output logic                   wdt_out,      // Timeout pin pulse
	output logic                   idle_allowed, // Idle entry unlocked
	output logic                   irq           // Level interrupt
);
	wd_state_t         state_r, state_nxt;
	logic [15:0]       key_r;
	logic [1:0]        idle_key_r;
	logic              flag_r, watchdog_enable_r, idle_ok_r, wdt_out_r, irq_r;
	logic [3:0]        gctl_r;
	logic [CNT_W-1:0]  cnt_r, prd_r, cnt_nxt;
	logic [IRQ_W-1:0]  ists_r, imask_r, ists_nxt;
	logic              wr_go, wr_hit, rd_go, rd_hit;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data, rd_data;
	logic [3:0]        wr_strb;
	logic              svc_armed, svc_done, svc_bad;
	logic              idle_done;

	axil_port u_port (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wr_go   (wr_go),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_hit  (wr_hit),
		.rd_go   (rd_go),
		.rd_data (rd_data),
		.rd_hit  (rd_hit)
	);

	// Register decode
	wire wr_ctrl  = wr_go && (wr_addr == OFF_CTRL);
	wire wr_gctl  = wr_go && (wr_addr == OFF_GCTL);
	wire wr_prdlo = wr_go && (wr_addr == OFF_PRDLO);
	wire wr_prdhi = wr_go && (wr_addr == OFF_PRDHI);
	wire wr_imask = wr_go && (wr_addr == OFF_IMASK);
	wire rd_ists  = rd_go && (araddr == OFF_ISTS);
	assign wr_hit = wr_addr[1:0] == 2'h0 && wr_addr <= OFF_IMASK;
	assign rd_hit = araddr[1:0] == 2'h0 && araddr <= OFF_IMASK;

	wire mode_wd  = gctl_r[MODE_LSB +: 2] == MODE_WD;
	wire run_both = gctl_r[UPRUN_BIT] && gctl_r[LORUN_BIT];
	wire enabled  = state_r != WD_INIT;
	wire active   = state_r == WD_ACTIVE;

	// Either upper byte strobe writes the whole key; a write that skips the upper bytes
	// leaves the key alone so flag and enable can be touched safely.
	wire key_wr  = wr_ctrl && (wr_strb[3] || wr_strb[2]);
	wire idle_wr = wr_ctrl && wr_strb[1] && mode_wd;
	wire [15:0] key_val  = wr_data[KEY_LSB +: 16];
	wire [1:0]  idle_val = wr_data[IDLE_LSB +: 2];

	key_seq #(.W(16), .FIRST(SVC_KEY1), .SECOND(SVC_KEY2)) u_svc (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (!enabled),
		.wr      (key_wr && enabled),
		.val     (key_val),
		.armed   (svc_armed),
		.done    (svc_done),
		.bad     (svc_bad)
	);

	key_seq #(.W(2), .FIRST(IDLE_KEY1), .SECOND(IDLE_KEY2)) u_idle (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (!mode_wd),
		.wr      (idle_wr),
		.val     (idle_val),
		.armed   (),
		.done    (idle_done),
		.bad     ()
	);

	wire period_hit = active && (cnt_r == prd_r);
	wire timeout    = (enabled && svc_bad) ||
		(period_hit && !svc_done);
	wire enter_act  = state_r == WD_PRE && svc_done && !timeout;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			WD_INIT:   if (watchdog_enable_r && mode_wd) state_nxt = WD_PRE;
			WD_PRE:    if (timeout) state_nxt = WD_INIT;
				else if (svc_done) state_nxt = WD_ACTIVE;
			WD_ACTIVE: if (timeout) state_nxt = WD_INIT;
			default:   state_nxt = WD_INIT;
		endcase
	end

	// Active ignores the half-run bits; outside active the count runs only with both run bits set
	always_comb begin
		cnt_nxt = cnt_r;
		if (active) begin
			if (svc_done || period_hit) cnt_nxt = '0;
			else cnt_nxt = cnt_r + 1'b1;
		end else if (enter_act) begin
			cnt_nxt = '0;
		end else if (run_both) begin
			cnt_nxt = (cnt_r >= prd_r) ? '0 : cnt_r + 1'b1;
		end
	end

	wire [IRQ_W-1:0] ev = {svc_bad && enabled, svc_done && enabled,
		timeout};
	// A new event in the clearing read survives it
	assign ists_nxt = ev | (rd_ists ? '0 : ists_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= WD_INIT;
			cnt_r   <= '0;
			ists_r  <= IRQ_RST;
			irq_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			ists_r  <= ists_nxt;
			irq_r   <= |(ists_nxt & imask_r);
		end
	end

	// Enable is set-only from software
	always_ff @(posedge aclk) begin
		if (!aresetn) watchdog_enable_r <= 1'b0;
		else if (timeout) watchdog_enable_r <= 1'b0;
		else if (wr_ctrl && wr_strb[1] && wr_data[EN_BIT])
			watchdog_enable_r <= 1'b1;
	end

	// Set beats the write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn) flag_r <= 1'b0;
		else if (timeout) flag_r <= 1'b1;
		else if (enter_act) flag_r <= 1'b0;
		else if (wr_ctrl && wr_strb[1] && wr_data[FLAG_BIT])
			flag_r <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_r      <= KEY_RST;
			idle_key_r <= IDLE_STOP;
			idle_ok_r  <= 1'b0;
		end else begin
			if (key_wr) key_r <= key_val;
			if (idle_wr) idle_key_r <= idle_val;
			if (idle_done) idle_ok_r <= 1'b1;
			else if (idle_wr && idle_val == IDLE_STOP)
				idle_ok_r <= 1'b0;
		end
	end

	// Pin only ever carries a timeout while enabled
	always_ff @(posedge aclk) begin
		if (!aresetn) wdt_out_r <= 1'b0;
		else wdt_out_r <= timeout && watchdog_enable_r;
	end

	// Mode and run bits are locked once enabled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gctl_r  <= GCTL_RST;
			prd_r   <= {2{PRD_RST}};
			imask_r <= IRQ_RST;
		end else begin
			if (wr_gctl && wr_strb[0] && !enabled)
				gctl_r <= wr_data[3:0];
			if (wr_prdlo) prd_r[31:0] <= wr_data;
			if (wr_prdhi) prd_r[63:32] <= wr_data;
			if (wr_imask) imask_r <= wr_data[IRQ_W-1:0];
		end
	end

	wire [31:0] ctrl_rd = {key_r, flag_r, watchdog_enable_r, idle_key_r,
		12'h000};
	assign rd_data =
		(araddr == OFF_CTRL)  ? ctrl_rd :
		(araddr == OFF_GCTL)  ? {28'h0000000, gctl_r} :
		(araddr == OFF_PRDLO) ? prd_r[31:0] :
		(araddr == OFF_PRDHI) ? prd_r[63:32] :
		(araddr == OFF_CNTLO) ? cnt_r[31:0] :
		(araddr == OFF_CNTHI) ? cnt_r[63:32] :
		(araddr == OFF_ISTS)  ? {29'h0, ists_r} :
		(araddr == OFF_IMASK) ? {29'h0, imask_r} :
		32'h0000_0000;

	assign wdt_out      = wdt_out_r;
	assign idle_allowed = idle_ok_r;
	assign irq          = irq_r;

	a_svc_order: assert property (@(posedge aclk) disable iff (!aresetn)
		(key_wr && enabled && key_val == SVC_KEY2 && !svc_armed)
		|-> !svc_done)
		else $error("service accepted without first key");

	a_bad_key_fires: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(key_wr && enabled && key_val != SVC_KEY1 && !svc_done)
		|=> flag_r && state_r == WD_INIT && !watchdog_enable_r)
		else $error("wrong key did not time out");

	a_gp_no_timeout: assert property (@(posedge aclk)
		disable iff (!aresetn) (state_r == WD_INIT) |-> !timeout)
		else $error("timeout outside watchdog");

	a_flag_on_active: assert property (@(posedge aclk)
		disable iff (!aresetn)
		$rose(active) |-> !flag_r)
		else $error("flag not cleared on activation");

	a_flag_sticky: assert property (@(posedge aclk)
		disable iff (!aresetn)
		timeout ##1 (!wr_ctrl && !enter_act) |=> flag_r)
		else $error("flag lost after timeout");

	a_pre_needs_en: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(state_r == WD_INIT && !(watchdog_enable_r && mode_wd))
		|=> state_r == WD_INIT)
		else $error("left initial state without enable");

	a_pin_quiet: assert property (@(posedge aclk)
		disable iff (!aresetn) !watchdog_enable_r |=> !wdt_out_r)
		else $error("pin driven while disabled");

	a_pin_follows: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(timeout && watchdog_enable_r) |=> wdt_out_r ##1 !wdt_out_r)
		else $error("pin did not pulse on timeout");

	a_en_holds: assert property (@(posedge aclk)
		disable iff (!aresetn) (watchdog_enable_r && !timeout) |=> watchdog_enable_r)
		else $error("enable dropped without timeout");

	a_idle_unlock: assert property (@(posedge aclk)
		disable iff (!aresetn) idle_done |=> idle_ok_r)
		else $error("idle not unlocked");

	a_idle_block: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(idle_wr && idle_val == IDLE_STOP) |=> (!idle_ok_r)[*2])
		else $error("idle not blocked by 00b");

	a_resv_zero: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(rd_go && araddr == OFF_CTRL) |=> rdata[11:0] == 12'h000)
		else $error("reserved bits read non-zero");

	a_mode_gate: assert property (@(posedge aclk)
		disable iff (!aresetn) $rose(enabled) |-> $past(mode_wd))
		else $error("entered watchdog outside mode 10b");

	a_active_runs: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(active && !period_hit && !svc_done && !timeout)
		|=> cnt_r == $past(cnt_r) + 1'b1)
		else $error("active counter stalled");

	a_svc_restart: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(active && svc_done && !timeout) |=> cnt_r == '0 && active)
		else $error("service did not restart count");
endmodule

// File: bench/watchdog_control_bench.sv
// Self-checking bench for the watchdog control block.
// Drives the AXI4-Lite register port by hand; no far-side model.
`timescale 1ns/1ps
module watchdog_control_bench;
	import wdt_pkg::*;

	logic              aclk;
	logic              aresetn;
	logic [ADDR_W-1:0] awaddr;
	logic              awvalid;
	logic              awready;
	logic [31:0]       wdata;
	logic [3:0]        wstrb;
	logic              wvalid;
	logic              wready;
	logic [1:0]        bresp;
	logic              bvalid;
	logic              bready;
	logic [ADDR_W-1:0] araddr;
	logic              arvalid;
	logic              arready;
	logic [31:0]       rdata;
	logic [1:0]        rresp;
	logic              rvalid;
	logic              rready;
	logic              wdt_out;
	logic              idle_allowed;
	logic              irq;
	int                bad_count = 0;
	int                compares = 0;
	int                pulses = 0;
	logic [1:0]        rresp_seen;

	watchdog_control #(.CNT_W(64)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.wdt_out(wdt_out), .idle_allowed(idle_allowed), .irq(irq)
	);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Every timeout pulse on the pin is counted here
	always @(posedge aclk) begin
		if (wdt_out === 1'b1)
			pulses <= pulses + 1;
	end

	task automatic give_verdict();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		int   n;
		logic ad;
		logic wd;
		logic bd;
		ad = 1'b0;
		wd = 1'b0;
		bd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40 && !bd; n++) begin
			@(posedge aclk);
			if (!ad && awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
			if (bvalid === 1'b1) begin
				bd = 1'b1;
				bready <= 1'b0;
				chk("bresp", {30'h0, bresp}, {30'h0, er});
			end
		end
		if (!bd) begin
			bad_count++;
			give_verdict();
		end
	endtask

	// Read one word, compare the masked value
	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] exp);
		int   n;
		logic t;
		logic got;
		logic [31:0] d;
		t = 1'b0;
		got = 1'b0;
		d = 32'h0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40 && !got; n++) begin
			@(posedge aclk);
			if (!t && arready === 1'b1) begin
				t = 1'b1;
				arvalid <= 1'b0;
			end
			if (rvalid === 1'b1) begin
				got = 1'b1;
				d = rdata;
				rresp_seen = rresp;
				rready <= 1'b0;
			end
		end
		if (!got) begin
			bad_count++;
			give_verdict();
		end else begin
			chk(nm, d & m, exp);
		end
	endtask

	task automatic key(input logic [15:0] k);
		axw(OFF_CTRL, {k, 16'h0000}, 4'hC, RESP_OK);
	endtask

	// Byte 1 only: flag, enable and idle key, service key untouched
	task automatic cw(input logic [31:0] d);
		axw(OFF_CTRL, d, 4'h2, RESP_OK);
	endtask

	task automatic t_reset();
		rchk("ctrl_rst", OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
		chk("rresp_ok", {30'h0, rresp_seen}, {30'h0, RESP_OK});
		rchk("gctl_rst", OFF_GCTL, 32'hFFFF_FFFF, 32'h0000_0000);
		rchk("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
		chk("rresp_err", {30'h0, rresp_seen}, {30'h0, RESP_ERR});
		axw(8'h40, 32'hFFFF_FFFF, 4'hF, RESP_ERR);
		chk("irq_rst", {31'h0, irq}, 32'h0);
		chk("idle_rst", {31'h0, idle_allowed}, 32'h0);
	endtask

	// General-purpose mode: keys and idle pattern must do nothing
	task automatic t_general();
		key(16'h1234);
		repeat (3) @(posedge aclk);
		chk("pulse_gp", pulses, 0);
		rchk("flag_gp", OFF_CTRL, 32'h0000_C000, 32'h0);
		cw(32'h0000_1000);
		cw(32'h0000_2000);
		chk("idle_gp", {31'h0, idle_allowed}, 32'h0);
		axw(OFF_CTRL, 32'h0000_0FFF, 4'h3, RESP_OK);
		rchk("resv", OFF_CTRL, 32'h0000_FFFF, 32'h0);
		// Two counts land between the run write and the read take
		axw(OFF_PRDLO, 32'h0000_003C, 4'hF, RESP_OK);
		axw(OFF_GCTL, 32'h0000_0003, 4'hF, RESP_OK);
		rchk("cnt_gp", OFF_CNTLO, 32'hFFFF_FFFF, 32'h0000_0002);
	endtask

	task automatic t_idle();
		axw(OFF_GCTL, {28'h0, MODE_WD, 2'b00}, 4'hF, RESP_OK);
		axw(OFF_PRDLO, 32'h0000_003C, 4'hF, RESP_OK);
		axw(OFF_PRDHI, 32'h0, 4'hF, RESP_OK);
		axw(OFF_IMASK, 32'h7, 4'hF, RESP_OK);
		key(SVC_KEY1);
		key(SVC_KEY2);
		rchk("svc_noen", OFF_ISTS, 32'hFFFF_FFFF, 32'h0);
		cw({18'h0, IDLE_KEY1, 12'h0});
		cw({18'h0, IDLE_KEY2, 12'h0});
		chk("idle_on", {31'h0, idle_allowed}, 32'h1);
		cw({18'h0, IDLE_STOP, 12'h0});
		chk("idle_stop", {31'h0, idle_allowed}, 32'h0);
		cw({18'h0, IDLE_KEY2, 12'h0});
		cw({18'h0, IDLE_KEY1, 12'h0});
		chk("idle_rev", {31'h0, idle_allowed}, 32'h0);
	endtask

	// Period 60: the second service lands inside it but the wait runs past it, so only a restart
	// keeps the pin quiet
	task automatic t_service();
		cw(32'h0000_4000);
		rchk("en_set", OFF_CTRL, 32'h0000_C000, 32'h0000_4000);
		key(SVC_KEY1);
		key(SVC_KEY2);
		chk("irq_svc", {31'h0, irq}, 32'h1);
		rchk("sts_svc", OFF_ISTS, 32'hFFFF_FFFF, 32'h2);
		repeat (2) @(posedge aclk);
		chk("irq_clr", {31'h0, irq}, 32'h0);
		cw(32'h0000_0000);
		rchk("en_hold", OFF_CTRL, 32'h0000_4000, 32'h0000_4000);
		axw(OFF_GCTL, 32'h0000_000B, 4'hF, RESP_OK);
		rchk("gctl_lock", OFF_GCTL, 32'hF, {28'h0, MODE_WD, 2'b00});
		key(SVC_KEY1);
		key(SVC_KEY2);
		repeat (40) @(posedge aclk);
		chk("restart", pulses, 0);
	endtask

	task automatic t_timeout();
		int n;
		for (n = 0; n < 100 && pulses == 0; n++)
			@(posedge aclk);
		chk("to_pulse", pulses, 1);
		repeat (2) @(posedge aclk);
		chk("to_width", pulses, 1);
		rchk("to_flag", OFF_CTRL, 32'h0000_C000, 32'h0000_8000);
		rchk("to_sts", OFF_ISTS, 32'h1, 32'h1);
	endtask

	task automatic t_badkey();
		cw(32'h0000_8000);
		rchk("flag_w1c", OFF_CTRL, 32'h0000_C000, 32'h0);
		cw(32'h0000_4000);
		axw(OFF_IMASK, 32'h0, 4'hF, RESP_OK);
		key(16'h1234);
		repeat (3) @(posedge aclk);
		chk("bad_pulse", pulses, 2);
		chk("irq_mask", {31'h0, irq}, 32'h0);
		rchk("bad_flag", OFF_CTRL, 32'h0000_C000, 32'h0000_8000);
		axw(OFF_IMASK, 32'h7, 4'hF, RESP_OK);
		repeat (2) @(posedge aclk);
		chk("irq_unmask", {31'h0, irq}, 32'h1);
		rchk("sts_bad", OFF_ISTS, 32'h4, 32'h4);
		repeat (2) @(posedge aclk);
		chk("irq_rdclr", {31'h0, irq}, 32'h0);
	endtask

	// Flag left set on purpose; entering active must wipe it
	task automatic t_reentry();
		cw(32'h0000_4000);
		key(SVC_KEY1);
		key(SVC_KEY2);
		rchk("flag_act", OFF_CTRL, 32'h0000_C000, 32'h0000_4000);
		chk("no_pulse", pulses, 2);
	endtask

	// Mid-run reset with flag, key and enable all set
	task automatic t_hwreset();
		key(16'h0001);
		cw(32'h0000_4000);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk("ctrl_hwrst", OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
		chk("pin_hwrst", {31'h0, wdt_out}, 32'h0);
	endtask

	initial begin
		repeat (100000) @(posedge aclk);
		bad_count++;
		give_verdict();
	end

	initial begin
		aresetn = 1'b0;
		awaddr = '0;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = '0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_general();
		t_idle();
		t_service();
		t_timeout();
		t_badkey();
		t_reentry();
		t_hwreset();
		give_verdict();
	end
endmodule
